//--- shared/lmi_pkg.sv
// Package: constants and types of the local memory interface
`default_nettype none
package lmi_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  // Extra peripheral window: sixteen bytes at a fixed base
  localparam logic [16:0] XP_BASE = 17'h1FFF0;
  localparam logic [16:0] XP_MASK = 17'h1FFF0;
  // Cycle timing in clocks
  localparam logic [1:0] SETUP_CYC  = 2'h1;
  localparam logic [1:0] STROBE_CYC = 2'h2;
  localparam logic [1:0] HOLD_CYC   = 2'h1;
  // Target selection codes
  typedef enum logic [1:0] {TGT_SRAM, TGT_FLASH, TGT_XP} lmi_tgt_type;
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD}
    lmi_state_type;
endpackage
`default_nettype wire

//--- shared/lmi_req_if.sv
// Interface: request from the chosen source to the memory sequencer
`timescale 1ns/1ps
`default_nettype none
interface lmi_req_if;
  import lmi_pkg::*;
  logic              valid;
  logic              ready;
  logic              write;
  logic              from_core;
  lmi_tgt_type       tgt;
  logic [16:0]       addr;
  logic [7:0]        wdata;
  modport src (output valid, output write, output from_core, output tgt,
               output addr, output wdata, input ready);
  modport dst (input valid, input write, input from_core, input tgt,
               input addr, input wdata, output ready);
endinterface
`default_nettype wire

//--- core/lmi_arb.sv
// Source arbiter: core first, host bus second, with window decode
`timescale 1ns/1ps
`default_nettype none
module lmi_arb
  import lmi_pkg::*;
(
  input  wire logic        i_core_valid,
  input  wire logic        i_core_write,
  input  wire logic        i_core_flash,
  input  wire logic [16:0] i_core_addr,
  input  wire logic [7:0]  i_core_wdata,
  output logic             o_core_ready,
  input  wire logic        i_host_valid,
  input  wire logic        i_host_write,
  input  wire logic        i_host_flash,
  input  wire logic [16:0] i_host_addr,
  input  wire logic [7:0]  i_host_wdata,
  output logic             o_host_ready,
  lmi_req_if.src           req
);
  wire core_xp = (i_core_addr & XP_MASK) == XP_BASE;
  assign req.valid     = i_core_valid | i_host_valid;
  assign req.from_core = i_core_valid;
  assign req.write     = i_core_valid ? i_core_write : i_host_write;
  assign req.addr      = i_core_valid ? i_core_addr : i_host_addr;
  assign req.wdata     = i_core_valid ? i_core_wdata : i_host_wdata;
  // Host never reaches the peripheral window
  assign req.tgt = i_core_valid ? (core_xp ? TGT_XP :
                   (i_core_flash ? TGT_FLASH : TGT_SRAM)) :
                   (i_host_flash ? TGT_FLASH : TGT_SRAM);
  assign o_core_ready = req.ready & i_core_valid;
  assign o_host_ready = req.ready & ~i_core_valid;
endmodule // lmi_arb
`default_nettype wire

//--- core/lmi_top.sv
// Top: local memory bus sequencer for SRAM, Flash and one peripheral
`timescale 1ns/1ps
`default_nettype none
module lmi_top
  import lmi_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_core_valid,
  input  wire logic        i_core_write,
  input  wire logic        i_core_flash,
  input  wire logic [16:0] i_core_addr,
  input  wire logic [7:0]  i_core_wdata,
  output logic             o_core_ready,
  input  wire logic        i_host_valid,
  input  wire logic        i_host_write,
  input  wire logic        i_host_flash,
  input  wire logic [16:0] i_host_addr,
  input  wire logic [7:0]  i_host_wdata,
  output logic             o_host_ready,
  output logic [7:0]       o_rdata,
  output logic             o_rdata_valid,
  output logic [16:0]      o_mem_addr,
  input  wire logic [7:0]  i_mem_data,
  output logic [7:0]       o_mem_data,
  output logic             o_mem_data_oe,
  output logic             o_flash_sel_n,
  output logic             o_sram_sel_n,
  output logic             o_extra_periph_sel_n,
  output logic             o_mem_read_gate_n,
  output logic             o_mem_write_strobe_n
);
  // ----------------------------------------------------------------
  // Request arbitration
  // ----------------------------------------------------------------
  lmi_req_if req ();
  lmi_arb u_arb (
    .i_core_valid (i_core_valid),
    .i_core_write (i_core_write),
    .i_core_flash (i_core_flash),
    .i_core_addr  (i_core_addr),
    .i_core_wdata (i_core_wdata),
    .o_core_ready (o_core_ready),
    .i_host_valid (i_host_valid),
    .i_host_write (i_host_write),
    .i_host_flash (i_host_flash),
    .i_host_addr  (i_host_addr),
    .i_host_wdata (i_host_wdata),
    .o_host_ready (o_host_ready),
    .req          (req)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  lmi_state_type state;
  lmi_tgt_type   tgt;
  logic          wr;
  logic [1:0]    cnt;
  logic [7:0]    din_s1;
  logic [7:0]    din_s2;

  wire idle_take = (state == ST_IDLE) & req.valid;
  assign req.ready = idle_take;
  wire cnt_done  = (cnt == 2'h1);
  wire strobe    = (state == ST_STROBE);

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state <= ST_IDLE;
      cnt   <= 2'h0;
      tgt   <= TGT_SRAM;
      wr    <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (req.valid)
          begin
            state <= ST_SETUP;
            cnt   <= SETUP_CYC;
            tgt   <= req.tgt;
            wr    <= req.write;
          end
        end
        ST_SETUP:
        begin
          if (cnt_done)
          begin
            state <= ST_STROBE;
            cnt   <= STROBE_CYC;
          end
          else
            cnt <= cnt - 2'h1;
        end
        ST_STROBE:
        begin
          if (cnt_done)
          begin
            state <= ST_HOLD;
            cnt   <= HOLD_CYC;
          end
          else
            cnt <= cnt - 2'h1;
        end
        ST_HOLD:
        begin
          if (cnt_done)
            state <= ST_IDLE;
          else
            cnt <= cnt - 2'h1;
        end
      endcase
    end
  end

  // Address and write data latched at take, held to cycle end
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_mem_addr <= 17'h00000;
      o_mem_data <= 8'h00;
    end
    else if (idle_take)
    begin
      o_mem_addr <= req.addr;
      o_mem_data <= req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Pin strobes, all registered
  // ----------------------------------------------------------------
  wire next_act = (state == ST_IDLE) ? req.valid :
                  !((state == ST_HOLD) & cnt_done);
  wire next_stb = ((state == ST_SETUP) & cnt_done) |
                  (strobe & !cnt_done);
  lmi_tgt_type next_tgt;
  logic        next_wr;
  assign next_tgt = (state == ST_IDLE) ? req.tgt : tgt;
  assign next_wr  = (state == ST_IDLE) ? req.write : wr;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_sram_sel_n         <= 1'b1;
      o_flash_sel_n        <= 1'b1;
      o_extra_periph_sel_n <= 1'b1;
      o_mem_read_gate_n    <= 1'b1;
      o_mem_write_strobe_n <= 1'b1;
      o_mem_data_oe        <= 1'b0;
    end
    else
    begin
      o_sram_sel_n  <= !(next_act & (next_tgt == TGT_SRAM));
      o_flash_sel_n <= !(next_act & (next_tgt == TGT_FLASH));
      o_extra_periph_sel_n <= !(next_act & (next_tgt == TGT_XP));
      o_mem_read_gate_n    <= !(next_stb & !next_wr);
      o_mem_write_strobe_n <= !(next_stb & next_wr);
      o_mem_data_oe        <= next_act & next_wr;
    end
  end

  // ----------------------------------------------------------------
  // Read data capture through two flops
  // ----------------------------------------------------------------
  wire rd_cap = strobe & cnt_done & !wr;
  logic rd_p1;
  logic rd_p2;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      din_s1        <= 8'h00;
      din_s2        <= 8'h00;
      rd_p1         <= 1'b0;
      rd_p2         <= 1'b0;
      o_rdata       <= 8'h00;
      o_rdata_valid <= 1'b0;
    end
    else
    begin
      din_s1        <= i_mem_data;
      din_s2        <= din_s1;
      rd_p1         <= rd_cap;
      rd_p2         <= rd_p1;
      o_rdata_valid <= rd_p2;
      if (rd_p2)
        o_rdata <= din_s2;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_one_select: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    $countones({o_sram_sel_n, o_flash_sel_n, o_extra_periph_sel_n}) >= 2)
    else $error("more than one select active");
  chk_xp_core_only: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (idle_take & !req.from_core) |=> o_extra_periph_sel_n [*4])
    else $error("peripheral select for host access");
  chk_xp_window: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    $fell(o_extra_periph_sel_n) |->
    ((o_mem_addr & XP_MASK) == XP_BASE))
    else $error("peripheral select outside window");
  chk_wr_addr_stable: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    !o_mem_write_strobe_n |-> $stable(o_mem_addr))
    else $error("address moved under write strobe");
  chk_wr_data_stable: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    $rose(o_mem_write_strobe_n) |->
    ($stable(o_mem_data) && o_mem_data_oe))
    else $error("write data not held at strobe rise");
  chk_rd_gate_sel: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    !o_mem_read_gate_n |-> (!o_mem_data_oe &&
    !(o_sram_sel_n && o_flash_sel_n && o_extra_periph_sel_n)))
    else $error("read gate without select or with drive");
  chk_flash_len: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    $fell(o_flash_sel_n) |-> !o_flash_sel_n [*4] ##1 o_flash_sel_n)
    else $error("flash select length wrong");
  chk_sram_strobe: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    $fell(o_sram_sel_n) |-> ##1 (!o_mem_read_gate_n ||
    !o_mem_write_strobe_n) [*2] ##1 (o_mem_read_gate_n &&
    o_mem_write_strobe_n && !o_sram_sel_n))
    else $error("sram cycle shape wrong");
  chk_addr_driven: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    idle_take |=> (o_mem_addr == $past(req.addr)))
    else $error("address not latched");
  chk_rd_return: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    rd_cap |-> ##3 (o_rdata_valid && (o_rdata == $past(i_mem_data, 3))))
    else $error("read data not returned");
endmodule // lmi_top
`default_nettype wire

//--- verif/lmi_mem_model.sv
// Partner model: SRAM, Flash and one peripheral on the memory bus
`timescale 1ns/1ps
`default_nettype none
module lmi_mem_model
(
  input  wire logic        i_clk_sys,
  input  wire logic [16:0] i_addr,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_data_oe,
  input  wire logic        i_flash_sel_n,
  input  wire logic        i_sram_sel_n,
  input  wire logic        i_xp_sel_n,
  input  wire logic        i_read_gate_n,
  input  wire logic        i_write_strobe_n,
  output logic [7:0]       o_data
);
  logic [7:0] sram  [0:131071];
  logic [7:0] flash [0:131071];
  logic [7:0] xp    [0:15];
  logic [7:0] last     = 8'h00;
  logic       strobe_q = 1'b1;
  logic [7:0] rd;

  // Part drives only while selected and gated
  always @*
  begin
    rd = ~last;
    if (!i_read_gate_n && !i_sram_sel_n)
      rd = sram[i_addr];
    else if (!i_read_gate_n && !i_flash_sel_n)
      rd = flash[i_addr];
    else if (!i_read_gate_n && !i_xp_sel_n)
      rd = xp[i_addr[3:0]];
  end
  // Wire level, controller wins while it drives
  assign o_data = i_data_oe ? i_data : rd;

  // Latch address and data at the strobe rise
  always @(posedge i_clk_sys)
  begin
    last <= o_data;
    strobe_q <= i_write_strobe_n;
    if (!strobe_q && i_write_strobe_n && !i_sram_sel_n)
      sram[i_addr] <= i_data;
    if (!strobe_q && i_write_strobe_n && !i_flash_sel_n)
      flash[i_addr] <= i_data;
    if (!strobe_q && i_write_strobe_n && !i_xp_sel_n)
      xp[i_addr[3:0]] <= i_data;
  end
endmodule // lmi_mem_model
`default_nettype wire

//--- verif/tb_top.sv
// Testbench: core accesses to SRAM, Flash and peripheral, host accesses to SRAM and Flash
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        i_clk_sys = 1'b0, i_rst = 1'b1, wr = 1'b0, fl = 1'b0;
  logic        i_core_valid = 1'b0, i_host_valid = 1'b0;
  logic [16:0] addr = 17'h00000, o_mem_addr, addr_q;
  logic [7:0]  wd = 8'h00, i_mem_data, o_rdata, o_mem_data, q;
  logic        o_core_ready, o_host_ready, o_rdata_valid, o_mem_data_oe;
  logic        o_flash_sel_n, o_sram_sel_n, o_extra_periph_sel_n;
  logic        o_mem_read_gate_n, o_mem_write_strobe_n, strobe_q;
  int          num_errors = 0, num_checks = 0, cycles = 0;

  always #5 i_clk_sys = ~i_clk_sys;

  lmi_top lmi_top_inst (.i_clk_sys, .i_rst, .i_core_valid,
    .i_core_write(wr), .i_core_flash(fl), .i_core_addr(addr),
    .i_core_wdata(wd), .o_core_ready, .i_host_valid,
    .i_host_write(wr), .i_host_flash(fl), .i_host_addr(addr),
    .i_host_wdata(wd), .o_host_ready, .o_rdata, .o_rdata_valid,
    .o_mem_addr, .i_mem_data, .o_mem_data, .o_mem_data_oe,
    .o_flash_sel_n, .o_sram_sel_n, .o_extra_periph_sel_n,
    .o_mem_read_gate_n, .o_mem_write_strobe_n);

  lmi_mem_model lmi_mem_model_inst (.i_clk_sys, .i_addr(o_mem_addr),
    .i_data(o_mem_data), .i_data_oe(o_mem_data_oe),
    .i_flash_sel_n(o_flash_sel_n), .i_sram_sel_n(o_sram_sel_n),
    .i_xp_sel_n(o_extra_periph_sel_n), .i_read_gate_n(o_mem_read_gate_n),
    .i_write_strobe_n(o_mem_write_strobe_n), .o_data(i_mem_data));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
  begin
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask

  task automatic print_verdict;
  begin
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask

  // One byte access; read data lands in q
  task automatic access(input logic h, input logic w, input logic f,
                        input logic [16:0] a, input logic [7:0] d);
    int n;
  begin
    n = 0;
    @(posedge i_clk_sys);
    wr <= w;
    fl <= f;
    addr <= a;
    wd <= d;
    i_core_valid <= !h;
    i_host_valid <= h;
    @(negedge i_clk_sys);
    while (!(h ? o_host_ready : o_core_ready) && n < 20)
    begin
      n++;
      @(negedge i_clk_sys);
    end
    if (n >= 20)
    begin
      num_errors++;
      $display("Error at %0t: request not taken", $time);
    end
    @(posedge i_clk_sys);
    i_core_valid <= 1'b0;
    i_host_valid <= 1'b0;
    n = 0;
    while (!w && !o_rdata_valid && n < 12)
    begin
      n++;
      @(negedge i_clk_sys);
    end
    if (n >= 12)
    begin
      num_errors++;
      $display("Error at %0t: read data not returned", $time);
    end
    q = o_rdata;
    repeat (6) @(negedge i_clk_sys);
  end
  endtask

  task automatic t_idle;
  begin
    check({2'h0, o_sram_sel_n, o_flash_sel_n, o_extra_periph_sel_n,
           o_mem_read_gate_n, o_mem_write_strobe_n, o_mem_data_oe},
          8'h3E);
    $display("test idle done");
  end
  endtask

  task automatic t_sram_flash;
  begin
    access(0, 1, 0, 17'h1ABCD, 8'hA5);
    access(0, 1, 0, 17'h0ABCD, 8'h5A);
    check(lmi_mem_model_inst.sram[17'h1ABCD], 8'hA5);
    access(0, 1, 1, 17'h1ABCD, 8'h3C);
    access(0, 0, 0, 17'h1ABCD, 8'h00);
    check(q, 8'hA5);
    access(0, 0, 1, 17'h1ABCD, 8'h00);
    check(q, 8'h3C);
    $display("test sram flash done");
  end
  endtask

  task automatic t_periph;
  begin
    access(0, 1, 1, 17'h1FFF7, 8'hC3);
    access(1, 1, 0, 17'h1FFF7, 8'h66);
    access(1, 1, 1, 17'h1FFF7, 8'h77);
    access(0, 1, 0, 17'h1FFEF, 8'h99);
    check(lmi_mem_model_inst.xp[7], 8'hC3);
    check(lmi_mem_model_inst.sram[17'h1FFF7], 8'h66);
    check(lmi_mem_model_inst.flash[17'h1FFF7], 8'h77);
    check(lmi_mem_model_inst.sram[17'h1FFEF], 8'h99);
    access(0, 0, 0, 17'h1FFF7, 8'h00);
    check(q, 8'hC3);
    access(1, 0, 0, 17'h1FFF7, 8'h00);
    check(q, 8'h66);
    $display("test peripheral done");
  end
  endtask

  // Bus watch: one select, steady address and driven data under strobe
  always @(negedge i_clk_sys)
  begin
    addr_q <= o_mem_addr;
    strobe_q <= o_mem_write_strobe_n;
    if (!i_rst && $countones({o_sram_sel_n, o_flash_sel_n,
        o_extra_periph_sel_n}) < 2)
    begin
      num_errors++;
      $display("Error at %0t: two selects low", $time);
    end
    if (!o_mem_write_strobe_n && (o_mem_data_oe !== 1'b1 ||
        (!strobe_q && o_mem_addr !== addr_q)))
    begin
      num_errors++;
      $display("Error at %0t: write cycle bus unstable", $time);
    end
  end

  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      $display("Error at %0t: timeout", $time);
      print_verdict();
    end
  end

  initial
  begin
    repeat (16) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(negedge i_clk_sys);
    t_idle();
    t_sram_flash();
    t_periph();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
